// [hdl/dsc_device.sv]
// dsc_device: device end of the debug stream ports, two-entry buffers each way
//
// Contract
// - ports exist only without internal scan phy
// - both ports run on the debug clock
// - device drops inbound ready when it cannot accept
// - receiver drops outbound ready to block transfers
// - valid high on every cycle a beat offered
// - channel 1 or 2 bits, routes 0,1,2
// - sop marks only first beat of packet
// - eop marks only last beat of packet
// - each beat carries eight payload bits
`timescale 1ns/10ps
`default_nettype none
module dsc_device #(
  parameter int CHAN_W = dsc_pkg::CHAN_W_SINGLE,
  parameter bit INTERNAL_SCAN_PHY_OPTION = 1'b0,
  parameter bit DEBUG_UNIT_OPTION = 1'b1
) (
  dsc_if.device lnk,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [CHAN_W-1:0] rx_channel,
  output logic rx_sop,
  output logic rx_eop,
  output logic [dsc_pkg::DATA_W-1:0] rx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [CHAN_W-1:0] tx_channel,
  input wire logic tx_sop,
  input wire logic tx_eop,
  input wire logic [dsc_pkg::DATA_W-1:0] tx_data,
  output logic ports_present,
  output logic rx_route_error
);
  // ************************************
  // types and state
  // ************************************
  localparam logic PRESENT = !INTERNAL_SCAN_PHY_OPTION && DEBUG_UNIT_OPTION;

  // one beat as it crosses either port
  typedef struct packed {
    logic [CHAN_W-1:0] channel;
    logic sop;
    logic eop;
    logic [dsc_pkg::DATA_W-1:0] data;
  } dsc_beat_s;

  // fill level of a two-entry buffer
  typedef logic [1:0] dsc_cnt_t;

  // two-entry buffer, index based
  typedef struct packed {
    dsc_beat_s [dsc_pkg::BUF_DEPTH-1:0] mem;
    dsc_cnt_t cnt;
    logic rd;
    logic wr;
  } dsc_fifo_s;

  // output stage that holds a beat until taken
  typedef struct packed {
    logic valid;
    dsc_beat_s beat;
  } dsc_stage_s;

  // one direction: buffer then stage
  typedef struct packed {
    dsc_fifo_s fifo;
    dsc_stage_s stage;
  } dsc_path_s;

  typedef struct packed {
    dsc_path_s ib;
    dsc_path_s ob;
    logic in_ready;
    logic tx_ready;
    logic route_err;
    logic present;
  } dsc_dev_s;

  dsc_dev_s s_q;
  dsc_dev_s s_d;

  // ************************************
  // helpers
  // ************************************
  // channel code outside the three routes
  function automatic logic dsc_bad_chan(
    input logic [CHAN_W-1:0] ch
  );
    logic [1:0] c;
    c = 2'h0;
    c[CHAN_W-1:0] = ch;
    dsc_bad_chan = (c != dsc_pkg::CHAN_CONVERTER)
      && (c != dsc_pkg::CHAN_DEBUG_UNIT_1)
      && (c != dsc_pkg::CHAN_DEBUG_UNIT_2);
  endfunction

  // fill level after at most one push and one pop
  function automatic dsc_cnt_t dsc_cnt_next(
    input dsc_cnt_t cnt,
    input logic push,
    input logic pop
  );
    dsc_cnt_next = cnt + dsc_cnt_t'(push) - dsc_cnt_t'(pop);
  endfunction

  // room for one more beat
  function automatic logic dsc_has_room(
    input dsc_cnt_t cnt
  );
    dsc_has_room = cnt < dsc_cnt_t'(dsc_pkg::BUF_DEPTH);
  endfunction

  // gather the loose fields of a beat
  function automatic dsc_beat_s dsc_pack(
    input logic [CHAN_W-1:0] channel,
    input logic sop,
    input logic eop,
    input logic [dsc_pkg::DATA_W-1:0] data
  );
    dsc_beat_s b;
    b.channel = channel;
    b.sop = sop;
    b.eop = eop;
    b.data = data;
    dsc_pack = b;
  endfunction

  // next state of one direction
  function automatic dsc_path_s dsc_path_next(
    input dsc_path_s p,
    input logic push,
    input dsc_beat_s beat,
    input logic take
  );
    dsc_path_s n;
    logic pop;
    n = p;
    pop = 1'b0;
    if (push) begin
      n.fifo.mem[p.fifo.wr] = beat;
      n.fifo.wr = ~p.fifo.wr;
    end
    if (take || !p.stage.valid) begin
      n.stage.valid = 1'b0;
    end
    if (!n.stage.valid && p.fifo.cnt != 2'h0) begin
      n.stage.valid = 1'b1;
      n.stage.beat = p.fifo.mem[p.fifo.rd];
      n.fifo.rd = ~p.fifo.rd;
      pop = 1'b1;
    end
    n.fifo.cnt = dsc_cnt_next(p.fifo.cnt, push, pop);
    dsc_path_next = n;
  endfunction

  // ************************************
  // next state
  // ************************************
  always_comb begin
    logic ib_push;
    logic ib_take;
    logic ob_push;
    logic ob_take;
    dsc_beat_s in_beat;
    dsc_beat_s tx_beat;
    in_beat = dsc_pack(lnk.in_channel, lnk.in_sop, lnk.in_eop, lnk.in_data);
    tx_beat = dsc_pack(tx_channel, tx_sop, tx_eop, tx_data);
    ib_push = PRESENT && lnk.in_valid && s_q.in_ready;
    ib_take = s_q.ib.stage.valid && rx_ready;
    ob_push = PRESENT && tx_valid && s_q.tx_ready;
    ob_take = s_q.ob.stage.valid && lnk.out_ready;
    s_d = s_q;
    s_d.present = PRESENT;
    s_d.ib = dsc_path_next(s_q.ib, ib_push, in_beat, ib_take);
    if (ib_push) begin
      s_d.route_err = dsc_bad_chan(lnk.in_channel);
    end
    s_d.in_ready = PRESENT && dsc_has_room(s_d.ib.fifo.cnt);
    s_d.ob = dsc_path_next(s_q.ob, ob_push, tx_beat, ob_take);
    s_d.tx_ready = PRESENT && dsc_has_room(s_d.ob.fifo.cnt);
  end

  // ************************************
  // registers on the debug clock
  // ************************************
  always_ff @(posedge lnk.ref_clk or posedge lnk.sys_rst) begin
    if (lnk.sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************
  // outputs
  // ************************************
  assign lnk.in_ready = s_q.in_ready;
  assign lnk.out_valid = s_q.ob.stage.valid;
  assign lnk.out_channel = s_q.ob.stage.beat.channel;
  assign lnk.out_sop = s_q.ob.stage.beat.sop;
  assign lnk.out_eop = s_q.ob.stage.beat.eop;
  assign lnk.out_data = s_q.ob.stage.beat.data;
  assign rx_valid = s_q.ib.stage.valid;
  assign rx_channel = s_q.ib.stage.beat.channel;
  assign rx_sop = s_q.ib.stage.beat.sop;
  assign rx_eop = s_q.ib.stage.beat.eop;
  assign rx_data = s_q.ib.stage.beat.data;
  assign tx_ready = s_q.tx_ready;
  assign ports_present = s_q.present;
  assign rx_route_error = s_q.route_err;
endmodule
`default_nettype wire

// [pkg/dsc_pkg.sv]
// dsc_pkg: shared constants for the debug stream channel ports
`default_nettype none
package dsc_pkg;
  localparam int DATA_W = 8;
  localparam int CHAN_W_SINGLE = 1;
  localparam int CHAN_W_DUAL = 2;
  localparam logic [1:0] CHAN_CONVERTER = 2'h0;
  localparam logic [1:0] CHAN_DEBUG_UNIT_1 = 2'h1;
  localparam logic [1:0] CHAN_DEBUG_UNIT_2 = 2'h2;
  localparam int BUF_DEPTH = 2;
endpackage
`default_nettype wire

// [pkg/dsc_if.sv]
// dsc_if: inbound and outbound debug stream links between device and partner
`timescale 1ns/10ps
`default_nettype none
interface dsc_if #(
  parameter int CHAN_W = dsc_pkg::CHAN_W_SINGLE
) (
  input wire logic ref_clk,
  input wire logic sys_rst
);
  logic in_ready;
  logic in_valid;
  logic [CHAN_W-1:0] in_channel;
  logic in_sop;
  logic in_eop;
  logic [dsc_pkg::DATA_W-1:0] in_data;
  logic out_ready;
  logic out_valid;
  logic [CHAN_W-1:0] out_channel;
  logic out_sop;
  logic out_eop;
  logic [dsc_pkg::DATA_W-1:0] out_data;

  modport device (
    input ref_clk, sys_rst,
    output in_ready,
    input in_valid, in_channel, in_sop, in_eop, in_data,
    input out_ready,
    output out_valid, out_channel, out_sop, out_eop, out_data
  );

  modport partner (
    input ref_clk, sys_rst,
    input in_ready,
    output in_valid, in_channel, in_sop, in_eop, in_data,
    output out_ready,
    input out_valid, out_channel, out_sop, out_eop, out_data
  );
endinterface
`default_nettype wire

// [hdl/dsc_partner.sv]
// dsc_partner: far end of the debug stream ports, two-entry buffers each way
`timescale 1ns/10ps
`default_nettype none
module dsc_partner #(
  parameter int CHAN_W = dsc_pkg::CHAN_W_SINGLE
) (
  dsc_if.partner lnk,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [CHAN_W-1:0] cmd_channel,
  input wire logic cmd_sop,
  input wire logic cmd_eop,
  input wire logic [dsc_pkg::DATA_W-1:0] cmd_data,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [CHAN_W-1:0] rsp_channel,
  output logic rsp_sop,
  output logic rsp_eop,
  output logic [dsc_pkg::DATA_W-1:0] rsp_data
);
  // ************************************
  // state
  // ************************************
  localparam int BEAT_W = CHAN_W + 2 + dsc_pkg::DATA_W;
  typedef logic [BEAT_W-1:0] dsc_pbeat_t;
  typedef struct packed {
    dsc_pbeat_t [dsc_pkg::BUF_DEPTH-1:0] cb_mem;
    logic [1:0] cb_cnt;
    logic cb_rd;
    logic cb_wr;
    dsc_pbeat_t [dsc_pkg::BUF_DEPTH-1:0] rb_mem;
    logic [1:0] rb_cnt;
    logic rb_rd;
    logic rb_wr;
    logic cmd_ready;
    logic out_ready;
    logic in_valid;
    logic rsp_valid;
    dsc_pbeat_t in_beat;
    dsc_pbeat_t rsp_beat;
  } dsc_par_s;

  dsc_par_s s_q;
  dsc_par_s s_d;

  // fill level after at most one push and one pop
  function automatic logic [1:0] dsc_pcnt_next(
    input logic [1:0] cnt,
    input logic push,
    input logic pop
  );
    dsc_pcnt_next = cnt + 2'(push) - 2'(pop);
  endfunction

  // room for one more beat
  function automatic logic dsc_proom(
    input logic [1:0] cnt
  );
    dsc_proom = cnt < 2'(dsc_pkg::BUF_DEPTH);
  endfunction

  // ************************************
  // next state
  // ************************************
  always_comb begin
    logic c_push;
    logic c_pop;
    logic r_push;
    logic r_pop;
    s_d = s_q;
    c_push = cmd_valid && s_q.cmd_ready;
    c_pop = s_q.in_valid && lnk.in_ready;
    r_push = lnk.out_valid && s_q.out_ready;
    r_pop = s_q.rsp_valid && rsp_ready;
    if (c_push) begin
      s_d.cb_mem[s_q.cb_wr] = {cmd_channel, cmd_sop, cmd_eop, cmd_data};
      s_d.cb_wr = ~s_q.cb_wr;
    end
    if (r_push) begin
      s_d.rb_mem[s_q.rb_wr] = {lnk.out_channel, lnk.out_sop, lnk.out_eop, lnk.out_data};
      s_d.rb_wr = ~s_q.rb_wr;
    end
    if (c_pop || !s_q.in_valid) begin
      s_d.in_valid = 1'b0;
    end
    if (!s_d.in_valid && s_q.cb_cnt != 2'h0) begin
      s_d.in_valid = 1'b1;
      s_d.in_beat = s_q.cb_mem[s_q.cb_rd];
      s_d.cb_rd = ~s_q.cb_rd;
    end
    s_d.cb_cnt = dsc_pcnt_next(s_q.cb_cnt, c_push, s_d.cb_rd != s_q.cb_rd);
    s_d.cmd_ready = dsc_proom(s_d.cb_cnt);
    if (r_pop || !s_q.rsp_valid) begin
      s_d.rsp_valid = 1'b0;
    end
    if (!s_d.rsp_valid && s_q.rb_cnt != 2'h0) begin
      s_d.rsp_valid = 1'b1;
      s_d.rsp_beat = s_q.rb_mem[s_q.rb_rd];
      s_d.rb_rd = ~s_q.rb_rd;
    end
    s_d.rb_cnt = dsc_pcnt_next(s_q.rb_cnt, r_push, s_d.rb_rd != s_q.rb_rd);
    s_d.out_ready = dsc_proom(s_d.rb_cnt);
  end

  always_ff @(posedge lnk.ref_clk or posedge lnk.sys_rst) begin
    if (lnk.sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************
  // outputs
  // ************************************
  assign lnk.in_valid = s_q.in_valid;
  assign {lnk.in_channel, lnk.in_sop, lnk.in_eop, lnk.in_data} = s_q.in_beat;
  assign lnk.out_ready = s_q.out_ready;
  assign cmd_ready = s_q.cmd_ready;
  assign rsp_valid = s_q.rsp_valid;
  assign {rsp_channel, rsp_sop, rsp_eop, rsp_data} = s_q.rsp_beat;
endmodule
`default_nettype wire

// [sim/dsc_sva.sv]
// dsc_sva: link checks between device and partner ends
`timescale 1ns/10ps
`default_nettype none
module dsc_sva #(
  parameter int CHAN_W = 1
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic in_ready,
  input wire logic in_valid,
  input wire logic [CHAN_W-1:0] in_channel,
  input wire logic in_sop,
  input wire logic in_eop,
  input wire logic [dsc_pkg::DATA_W-1:0] in_data,
  input wire logic out_ready,
  input wire logic out_valid,
  input wire logic [CHAN_W-1:0] out_channel,
  input wire logic out_sop,
  input wire logic out_eop,
  input wire logic [dsc_pkg::DATA_W-1:0] out_data
);
  // ****
  // packet tracking
  // ****
  logic in_open_q;
  logic out_open_q;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      in_open_q <= 1'b0;
      out_open_q <= 1'b0;
    end else begin
      if (in_valid && in_ready) in_open_q <= !in_eop;
      if (out_valid && out_ready) out_open_q <= !out_eop;
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence s_in_take;
    in_valid && in_ready;
  endsequence
  sequence s_out_take;
    out_valid && out_ready;
  endsequence
  a_in_hold: assert property (in_valid && !in_ready |=>
    in_valid && $stable({in_channel, in_sop, in_eop, in_data})) else $error("inbound beat moved");
  a_out_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable({out_channel, out_sop, out_eop, out_data})) else $error("outbound beat moved");
  a_in_chan: assert property (in_valid |-> in_channel <= dsc_pkg::CHAN_DEBUG_UNIT_2)
    else $error("inbound channel code");
  a_out_chan: assert property (out_valid |-> out_channel <= dsc_pkg::CHAN_DEBUG_UNIT_2)
    else $error("outbound channel code");
  a_in_frame: assert property (s_in_take |-> in_sop == !in_open_q)
    else $error("inbound start marker");
  a_out_frame: assert property (s_out_take |-> out_sop == !out_open_q)
    else $error("outbound start marker");
  a_rst_idle: assert property ($fell(sys_rst) |-> !in_valid && !out_valid)
    else $error("valid right after reset");
  a_ready_rise: assert property ($fell(sys_rst) |=> in_ready && out_ready)
    else $error("ready not raised after reset");
  a_in_room: assert property (in_ready && !in_valid |=> in_ready)
    else $error("inbound ready dropped with room");
  a_out_room: assert property (out_ready && !out_valid |=> out_ready)
    else $error("outbound ready dropped with room");
endmodule
`default_nettype wire

// [sim/dsc_bench.sv]
// dsc_bench: random packets both ways across the joined ends
`timescale 1ns/10ps
`default_nettype none
module dsc_bench;
  localparam int CW = 2;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_v = 1'b0, tx_v = 1'b0, rx_r = 1'b0, rsp_r = 1'b0;
  logic [11:0] cmd_b = 12'h000, tx_b = 12'h000;
  wire [11:0] rx_b, rsp_b;
  wire cmd_r, tx_r, rx_v, rsp_v, present, rerr;
  logic [11:0] q_in[$], q_out[$];
  logic [31:0] seed = 32'h29;
  logic [31:0] r;
  bit go, rand_rdy, cmd_took, tx_took, open_c, open_t;
  int fail_count, checks;
  dsc_if #(.CHAN_W(CW)) i_lnk (.ref_clk(ref_clk), .sys_rst(sys_rst));
  dsc_device #(.CHAN_W(CW)) i_dsc_device (.lnk(i_lnk), .rx_valid(rx_v), .rx_ready(rx_r),
    .rx_channel(rx_b[11:10]), .rx_sop(rx_b[9]), .rx_eop(rx_b[8]), .rx_data(rx_b[7:0]),
    .tx_valid(tx_v), .tx_ready(tx_r), .tx_channel(tx_b[11:10]), .tx_sop(tx_b[9]),
    .tx_eop(tx_b[8]), .tx_data(tx_b[7:0]), .ports_present(present), .rx_route_error(rerr));
  dsc_partner #(.CHAN_W(CW)) i_dsc_partner (.lnk(i_lnk), .cmd_valid(cmd_v), .cmd_ready(cmd_r),
    .cmd_channel(cmd_b[11:10]), .cmd_sop(cmd_b[9]), .cmd_eop(cmd_b[8]), .cmd_data(cmd_b[7:0]),
    .rsp_valid(rsp_v), .rsp_ready(rsp_r), .rsp_channel(rsp_b[11:10]), .rsp_sop(rsp_b[9]),
    .rsp_eop(rsp_b[8]), .rsp_data(rsp_b[7:0]));
  // second device built with the internal scan phy: its ports stay idle
  dsc_if #(.CHAN_W(CW)) i_off (.ref_clk(ref_clk), .sys_rst(sys_rst));
  wire [11:0] off_rx_b;
  wire off_rx_v, off_tx_r, off_present, off_rerr;
  assign i_off.in_valid = cmd_v;
  assign {i_off.in_channel, i_off.in_sop, i_off.in_eop, i_off.in_data} = cmd_b;
  assign i_off.out_ready = rsp_r;
  dsc_device #(.CHAN_W(CW), .INTERNAL_SCAN_PHY_OPTION(1'b1)) i_dsc_device_off (.lnk(i_off),
    .rx_valid(off_rx_v), .rx_ready(rx_r), .rx_channel(off_rx_b[11:10]), .rx_sop(off_rx_b[9]),
    .rx_eop(off_rx_b[8]), .rx_data(off_rx_b[7:0]), .tx_valid(tx_v), .tx_ready(off_tx_r),
    .tx_channel(tx_b[11:10]), .tx_sop(tx_b[9]), .tx_eop(tx_b[8]), .tx_data(tx_b[7:0]),
    .ports_present(off_present), .rx_route_error(off_rerr));
  wire [5:0] off_st = {off_present, off_rx_v, off_tx_r, i_off.in_ready, i_off.out_valid, off_rerr};
  dsc_sva #(.CHAN_W(CW)) i_dsc_sva (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .in_ready(i_lnk.in_ready), .in_valid(i_lnk.in_valid), .in_channel(i_lnk.in_channel),
    .in_sop(i_lnk.in_sop), .in_eop(i_lnk.in_eop), .in_data(i_lnk.in_data),
    .out_ready(i_lnk.out_ready), .out_valid(i_lnk.out_valid), .out_channel(i_lnk.out_channel),
    .out_sop(i_lnk.out_sop), .out_eop(i_lnk.out_eop), .out_data(i_lnk.out_data));
  // ****
  // helpers
  // ****
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic drive(ref logic v, ref logic [11:0] b, ref bit open);
    logic [31:0] x;
    x = rnd();
    if (v) open = !b[8];
    v = x[0] | x[1];
    b = {2'(x[3:2] % 2'h3), !open, x[4], x[12:5]};
  endtask
  task mis(input string m);
    fail_count++;
    $display("mismatch %0t %s", $time, m);
  endtask
  task results;
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ****
  // stimulus and scoreboard
  // ****
  initial forever #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (cmd_v && cmd_r) q_in.push_back(cmd_b);
    if (tx_v && tx_r) q_out.push_back(tx_b);
    if (rx_v && rx_r) checks++;
    if (rx_v && rx_r && (q_in.size() == 0 || rx_b !== q_in.pop_front())) mis("inbound");
    if (rsp_v && rsp_r) checks++;
    if (rsp_v && rsp_r && (q_out.size() == 0 || rsp_b !== q_out.pop_front())) mis("out");
    if (go && (present !== 1'b1 || rerr !== 1'b0)) mis("port state");
    if (go && off_st !== 6'h00) mis("absent port active");
  end
  always @(posedge ref_clk) begin
    cmd_took = cmd_v && cmd_r;
    tx_took = tx_v && tx_r;
    #1;
    r = rnd();
    if (rand_rdy) {rx_r, rsp_r} = r[1:0];
    if (go && (cmd_took || !cmd_v)) drive(cmd_v, cmd_b, open_c);
    else if (cmd_took) cmd_v = 1'b0;
    if (go && (tx_took || !tx_v)) drive(tx_v, tx_b, open_t);
    else if (tx_took) tx_v = 1'b0;
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    @(posedge ref_clk);
    #2 go = 1'b1;
    repeat (12) @(posedge ref_clk);
    #2 checks++;
    if (i_lnk.in_ready !== 1'b0) mis("inbound not refused when full");
    if (i_lnk.out_ready !== 1'b0) mis("outbound not refused when full");
    rand_rdy = 1'b1;
    repeat (1500) @(posedge ref_clk);
    go = 1'b0;
    for (int i = 0; i < 100 && (q_in.size() || q_out.size() || cmd_v || tx_v); i++) begin
      @(posedge ref_clk);
    end
    if (q_in.size() || q_out.size() || cmd_v || tx_v) mis("drain timeout");
    results();
  end
endmodule
`default_nettype wire
